// *** core/svcr_pkg.sv ***
// package: offsets, reset values and field layout of the oscillator-core configuration bank
package svcr_pkg;
  localparam int unsigned SVCR_AW = 8;
  localparam int unsigned SVCR_DW = 16;
  localparam int unsigned SVCR_NREG = 9;

  localparam logic [7:0] SVCR_OFS_CORE_CTRL = 8'h14;
  localparam logic [7:0] SVCR_OFS_RSV_A = 8'h15;
  localparam logic [7:0] SVCR_OFS_RSV_B = 8'h16;
  localparam logic [7:0] SVCR_OFS_RSV_C = 8'h17;
  localparam logic [7:0] SVCR_OFS_RSV_D = 8'h18;
  localparam logic [7:0] SVCR_OFS_RSV_E = 8'h19;
  localparam logic [7:0] SVCR_OFS_RSV_F = 8'h1a;
  localparam logic [7:0] SVCR_OFS_RSV_G = 8'h1b;
  localparam logic [7:0] SVCR_OFS_RSV_H = 8'h1c;

  localparam logic [15:0] SVCR_RST_CORE_CTRL = 16'h3048;
  localparam logic [15:0] SVCR_RST_RSV_A = 16'h0401;
  localparam logic [15:0] SVCR_RST_RSV_B = 16'h0001;
  localparam logic [15:0] SVCR_RST_RSV_C = 16'h007c;
  localparam logic [15:0] SVCR_RST_RSV_D = 16'h071a;
  localparam logic [15:0] SVCR_RST_RSV_E = 16'h0624;
  localparam logic [15:0] SVCR_RST_RSV_F = 16'h0db0;
  localparam logic [15:0] SVCR_RST_RSV_G = 16'h0002;
  localparam logic [15:0] SVCR_RST_RSV_H = 16'h0488;

  // control register field positions
  localparam int unsigned SVCR_SEL_LSB = 11;
  localparam int unsigned SVCR_SEL_MSB = 13;
  localparam int unsigned SVCR_FORCE_BIT = 10;
  localparam int unsigned SVCR_HI_LSB = 14;
  localparam int unsigned SVCR_LO_MSB = 9;
  localparam logic [2:0] SVCR_SEL_RST = 3'h6;
  localparam logic [1:0] SVCR_HI_PROG = 2'h3;
  localparam logic [9:0] SVCR_LO_PROG = 10'h048;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } svcr_req_t;

  typedef struct packed {
    logic [2:0] start_core_select;
    logic core_force_enable;
  } svcr_core_t;
endpackage : svcr_pkg

// *** core/svcr_top.sv ***
// file: oscillator-core configuration register bank with plain register port
`timescale 1ns/1ps
`default_nettype none
module svcr_top (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic srst, // synchronous reset, high
  input wire svcr_pkg::svcr_req_t req, // address, write data, strobes
  output logic [15:0] rdata, // read data, one cycle after read strobe
  output logic rvalid, // read data valid pulse
  output var svcr_pkg::svcr_core_t core_ctrl // start core and force to calibration
);
  import svcr_pkg::*;

  // ****************************************************************
  // register words
  // ****************************************************************
  localparam logic [7:0] OFS [SVCR_NREG] = '{SVCR_OFS_CORE_CTRL, SVCR_OFS_RSV_A,
    SVCR_OFS_RSV_B, SVCR_OFS_RSV_C, SVCR_OFS_RSV_D, SVCR_OFS_RSV_E, SVCR_OFS_RSV_F,
    SVCR_OFS_RSV_G, SVCR_OFS_RSV_H};
  localparam logic [15:0] RSTV [SVCR_NREG] = '{SVCR_RST_CORE_CTRL, SVCR_RST_RSV_A,
    SVCR_RST_RSV_B, SVCR_RST_RSV_C, SVCR_RST_RSV_D, SVCR_RST_RSV_E, SVCR_RST_RSV_F,
    SVCR_RST_RSV_G, SVCR_RST_RSV_H};

  // one-hot decode of an address onto the bank
  function automatic logic [SVCR_NREG-1:0] svcr_dec(input logic [7:0] a);
    logic [SVCR_NREG-1:0] h;
    h = '0;
    for (int i = 0; i < SVCR_NREG; i++) begin
      h[i] = (a == OFS[i]);
    end
    return h;
  endfunction : svcr_dec

  logic [SVCR_NREG-1:0] hit;
  logic [15:0] word_q [SVCR_NREG];

  assign hit = svcr_dec(req.addr);

  genvar g;
  generate
    for (g = 0; g < SVCR_NREG; g++) begin : g_word
      // reset values of every word, reserved ones included
      svcr_word #(.RST(RSTV[g])) u_word (
        .ref_clk(ref_clk),
        .srst(srst),
        .we(req.wr && hit[g]),
        .wdata(req.wdata),
        .q(word_q[g])
      );
    end
  endgenerate

  // ****************************************************************
  // read path and core-control outputs
  // ****************************************************************
  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
    svcr_core_t core;
  } svcr_st_t;

  svcr_st_t st_q;
  svcr_st_t st_d;
  logic [15:0] ctrl_w;

  assign ctrl_w = word_q[0];

  always_comb begin
    st_d = st_q;
    st_d.rvalid = req.rd;
    st_d.rdata = '0;
    if (req.rd) begin
      // unmapped offsets read as zero
      for (int i = 0; i < SVCR_NREG; i++) begin
        if (hit[i]) begin
          st_d.rdata = word_q[i];
        end
      end
    end
    // next-cycle view of the control word so outputs change on the same edge as the word
    if (req.wr && hit[0]) begin
      st_d.core.start_core_select = req.wdata[SVCR_SEL_MSB:SVCR_SEL_LSB];
      st_d.core.core_force_enable = req.wdata[SVCR_FORCE_BIT];
    end else begin
      st_d.core.start_core_select = ctrl_w[SVCR_SEL_MSB:SVCR_SEL_LSB];
      st_d.core.core_force_enable = ctrl_w[SVCR_FORCE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q.rdata <= 16'h0000;
      st_q.rvalid <= 1'b0;
      st_q.core.start_core_select <= SVCR_SEL_RST;
      st_q.core.core_force_enable <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign rvalid = st_q.rvalid;
  assign core_ctrl = st_q.core;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ctrl_reset_val: assert property (@(posedge ref_clk)
    $past(srst) |-> (ctrl_w == 16'h3048))
    else $error("control word not 0x3048 after reset");
  a_core_reset_val: assert property (@(posedge ref_clk)
    $past(srst) |-> (core_ctrl.start_core_select == SVCR_SEL_RST &&
    !core_ctrl.core_force_enable))
    else $error("core outputs not at reset values after reset");
  a_core_sel_track: assert property (@(posedge ref_clk) disable iff (srst)
    (req.wr && req.addr == 8'h14) |=>
    (core_ctrl.start_core_select == $past(req.wdata[13:11])))
    else $error("start core output did not follow write");
  a_force_bit_write: assert property (@(posedge ref_clk) disable iff (srst)
    (req.wr && req.addr == 8'h14) |=>
    (core_ctrl.core_force_enable == $past(req.wdata[10])))
    else $error("force output did not follow write");
  a_core_sel_match: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 (core_ctrl.start_core_select == ctrl_w[13:11]))
    else $error("start core output differs from stored field");
  a_force_bit_track: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 (core_ctrl.core_force_enable == ctrl_w[10]))
    else $error("force output differs from stored bit");
  a_rsv_a_reset: assert property (@(posedge ref_clk)
    $past(srst) |-> (word_q[1] == 16'h0401 && word_q[2] == 16'h0001))
    else $error("reserved a/b reset value wrong");
  a_rsv_c_reset: assert property (@(posedge ref_clk)
    $past(srst) |-> (word_q[3] == 16'h007c && word_q[4] == 16'h071a))
    else $error("reserved c/d reset value wrong");
  a_rsv_e_reset: assert property (@(posedge ref_clk)
    $past(srst) |-> (word_q[5] == 16'h0624 && word_q[6] == 16'h0db0))
    else $error("reserved e/f reset value wrong");
  a_rsv_g_reset: assert property (@(posedge ref_clk)
    $past(srst) |-> (word_q[7] == 16'h0002 && word_q[8] == 16'h0488))
    else $error("reserved g/h reset value wrong");
  a_read_after_write: assert property (@(posedge ref_clk) disable iff (srst)
    (req.wr && req.addr >= 8'h14 && req.addr <= 8'h1c) ##1
    (req.rd && req.addr == $past(req.addr)) |=> (rvalid && rdata == $past(req.wdata, 2)))
    else $error("read did not return the written value");
  a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (srst)
    req.rd |=> rvalid ##1 (rvalid == $past(req.rd)))
    else $error("read data valid not one cycle after strobe");
  a_read_idle_zero: assert property (@(posedge ref_clk) disable iff (srst)
    !req.rd |=> (!rvalid && rdata == 16'h0000))
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (req.rd && hit == '0) |=> (rvalid && rdata == 16'h0000))
    else $error("unmapped read did not return zero");
endmodule : svcr_top
`default_nettype wire

// *** core/svcr_word.sv ***
// file: one sixteen-bit read-write register word with a fixed reset value
`timescale 1ns/1ps
`default_nettype none
module svcr_word #(
  parameter logic [15:0] RST = 16'h0000
) (
  input wire logic ref_clk, // clock
  input wire logic srst, // synchronous reset, high
  input wire logic we, // write this word
  input wire logic [15:0] wdata, // write data
  output logic [15:0] q // stored value
);
  import svcr_pkg::*;

  typedef struct packed {
    logic [15:0] val;
  } svcr_word_st_t;

  svcr_word_st_t st_q;
  svcr_word_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (we) begin
      st_d.val = wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '{val: RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.val;

  a_word_write_holds: assert property (@(posedge ref_clk) disable iff (srst)
    we |=> (q == $past(wdata)))
    else $error("word did not store written data");
  a_word_idle_holds: assert property (@(posedge ref_clk) disable iff (srst)
    !we |=> $stable(q))
    else $error("word changed without a write");
endmodule : svcr_word
`default_nettype wire

// *** tb/tb.sv ***
// testbench: oscillator-core configuration bank, register port and core controls
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  import svcr_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  svcr_req_t req = '0;
  logic [15:0] rdata;
  logic rvalid;
  svcr_core_t core_ctrl;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] ofs [9];
  logic [15:0] rstv [9];
  svcr_top uut (.ref_clk(ref_clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .core_ctrl(core_ctrl));
  always #5 ref_clk = ~ref_clk;
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
    @(negedge ref_clk);
    `CHK({rvalid, rdata}, 17'h00000)
  endtask : rd_chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      rd_chk(ofs[i], rstv[i]);
    end
    `CHK(core_ctrl.start_core_select, 3'h6)
    `CHK(core_ctrl.core_force_enable, 1'b0)
    $display("reset values done");
  endtask : t_reset
  task automatic t_rw;
    for (int i = 0; i < 9; i++) wr(ofs[i], ~rstv[i]);
    for (int i = 0; i < 9; i++) rd_chk(ofs[i], ~rstv[i]);
    // host programming values, control word gets 0x3 on top
    wr(ofs[0], 16'hf048);
    for (int i = 1; i < 9; i++) begin
      wr(ofs[i], rstv[i]);
    end
    rd_chk(ofs[0], 16'hf048);
    for (int i = 1; i < 9; i++) rd_chk(ofs[i], rstv[i]);
    $display("read-write done");
  endtask : t_rw
  task automatic t_core;
    for (int s = 1; s < 8; s++) begin
      for (int f = 0; f < 2; f++) begin
        wr(ofs[0], {2'h3, 3'(s), 1'(f), 10'h048});
        `CHK(core_ctrl.start_core_select, 3'(s))
        `CHK(core_ctrl.core_force_enable, 1'(f))
      end
    end
    rd_chk(ofs[0], 16'hfc48);
    $display("core select done");
  endtask : t_core
  task automatic t_unmapped;
    wr(8'h13, 16'hffff);
    wr(8'h1d, 16'hffff);
    rd_chk(8'h13, 16'h0000);
    rd_chk(8'h1d, 16'h0000);
    rd_chk(ofs[0], 16'hfc48);
    rd_chk(ofs[8], rstv[8]);
    `CHK(core_ctrl.start_core_select, 3'h7)
    $display("unmapped done");
  endtask : t_unmapped
  task automatic t_b2b;
    // write then read of the same word with no gap between the strobes
    @(posedge ref_clk);
    req.addr <= ofs[4];
    req.wdata <= 16'h1234;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, 16'h1234)
    wr(ofs[4], rstv[4]);
    rd_chk(ofs[4], rstv[4]);
    $display("back-to-back done");
  endtask : t_b2b
  task automatic t_rerst;
    for (int i = 0; i < 9; i++) wr(ofs[i], 16'h5a5a);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    $display("second reset done");
  endtask : t_rerst
  // ****************************************
  // main sequence and timeout
  // ****************************************
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    ofs = '{SVCR_OFS_CORE_CTRL, SVCR_OFS_RSV_A, SVCR_OFS_RSV_B, SVCR_OFS_RSV_C, SVCR_OFS_RSV_D,
      SVCR_OFS_RSV_E, SVCR_OFS_RSV_F, SVCR_OFS_RSV_G, SVCR_OFS_RSV_H};
    rstv = '{16'h3048, 16'h0401, 16'h0001, 16'h007c, 16'h071a, 16'h0624, 16'h0db0, 16'h0002,
      16'h0488};
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_core();
    t_unmapped();
    t_b2b();
    t_rerst();
    test_done();
  end
endmodule : tb
`default_nettype wire
